//--- hw/sjd_consts.svh
// constants for the scan-port instruction decoder
// assumes inclusion by bare name from every design file that needs them
`ifndef SJD_CONSTS_SVH
`define SJD_CONSTS_SVH

// ==========================================================
// widths
`define SJD_IR_W 3
`define SJD_ID_W 32
`define SJD_BSR_W 8

// ==========================================================
// instruction codes, msb on the left
`define SJD_OP_EXTEST 3'h0
`define SJD_OP_IDCODE 3'h1
`define SJD_OP_SAMPLEZ 3'h2
`define SJD_OP_RESV_A 3'h3
`define SJD_OP_SAMPLE 3'h4
`define SJD_OP_PRIVATE 3'h5
`define SJD_OP_RESV_B 3'h6
`define SJD_OP_BYPASS 3'h7

// ==========================================================
// capture and reset values
`define SJD_IR_CAPTURE 3'h1
`define SJD_IR_RESET `SJD_OP_IDCODE
`define SJD_BYPASS_CAPTURE 1'h0
`define SJD_TDO_RESET 1'h0

`endif

//--- hw/sjd_pkg.sv
// types shared by the scan-port instruction decoder
// assumes sjd_consts.svh is on the include path
package sjd_pkg;

  // ==========================================================
  // serial port pins, all from the far controller
  typedef struct packed {
    logic tck;
    logic tms;
    logic tdi;
  } sjd_pins_t;

  // ==========================================================
  // test access port states, one-hot
  typedef enum logic [15:0] {
    TLR = 16'h0001,
    RTI = 16'h0002,
    SEL_DR = 16'h0004,
    CAP_DR = 16'h0008,
    SH_DR = 16'h0010,
    EX1_DR = 16'h0020,
    PAU_DR = 16'h0040,
    EX2_DR = 16'h0080,
    UPD_DR = 16'h0100,
    SEL_IR = 16'h0200,
    CAP_IR = 16'h0400,
    SH_IR = 16'h0800,
    EX1_IR = 16'h1000,
    PAU_IR = 16'h2000,
    EX2_IR = 16'h4000,
    UPD_IR = 16'h8000
  } sjd_tap_state_t;

endpackage : sjd_pkg

//--- hw/sjd_pin_sync.sv
// two-stage synchroniser for the scan pins plus test-clock edge finder
// assumes pins are asynchronous to clk and test clock is far slower
`timescale 1ns/1ps
`default_nettype none

module sjd_pin_sync (
  input wire logic clk,
  input wire logic reset,
  input wire sjd_pkg::sjd_pins_t pins,
  output logic tmsSync,
  output logic tdiSync,
  output logic tckRise,
  output logic tckFall
);
  import sjd_pkg::*;

  // ==========================================================
  // synchroniser: stage one feeds stage two only
  sjd_pins_t meta_q;
  sjd_pins_t sync_q;
  logic tckPrev_q;

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      meta_q <= '0;
      sync_q <= '0;
      tckPrev_q <= 1'b0;
    end
    else
    begin
      meta_q <= pins;
      sync_q <= meta_q;
      tckPrev_q <= sync_q.tck;
    end
  end

  // ==========================================================
  // edge pulses, one clk wide
  assign tmsSync = sync_q.tms;
  assign tdiSync = sync_q.tdi;
  assign tckRise = sync_q.tck & ~tckPrev_q;
  assign tckFall = ~sync_q.tck & tckPrev_q;

endmodule : sjd_pin_sync

`default_nettype wire

//--- hw/sjd_tap_decoder.sv
// scan-port controller with instruction decode for a burst ram
// assumes test clock far slower than clk; ring pins asynchronous
// Functional notes
// - code 000 is external test; boundary register sits in the scan path
// - code 001 is identification; register preloaded and placed in scan path
// - code 010 captures ring, uses boundary register, forces ram drivers high-z
// - codes 011 and 110 act as bypass; controller should not issue them
// - code 100 is sample/preload; captures ring into boundary register
// - code 111 is bypass; one-stage register is the whole path
// - power-up and test-logic-reset load identification instruction
// - codes are msb-left three bits; shifted lsb first by both sides
// - capture-ir loads 01 in low bits; new code acts only at update-ir
// - identification register is 32 bits, captured in capture-dr, bit 0 first
// - under external test boundary update cells drive ram outputs; inputs still act
`timescale 1ns/1ps
`default_nettype none
`include "sjd_consts.svh"

module sjd_tap_decoder #(
  // arbitrary identification value; bit 0 kept high as presence marker
  parameter logic [`SJD_ID_W-1:0] ID_VALUE = 32'h1A5C_0F03
) (
  input wire logic clk,
  input wire logic reset,
  input wire sjd_pkg::sjd_pins_t pins,
  input wire logic [`SJD_BSR_W-1:0] ringIn,
  output logic tdo,
  output logic tdoEnable,
  output logic ramHighZ,
  output logic ramDriveScan,
  output logic [`SJD_BSR_W-1:0] ramPinOut,
  output logic [`SJD_IR_W-1:0] activeInstr
);
  import sjd_pkg::*;

  // ==========================================================
  // pin synchronisation
  logic tmsSync;
  logic tdiSync;
  logic tckRise;
  logic tckFall;

  sjd_pin_sync u_sync (
    .clk(clk),
    .reset(reset),
    .pins(pins),
    .tmsSync(tmsSync),
    .tdiSync(tdiSync),
    .tckRise(tckRise),
    .tckFall(tckFall)
  );

  // ring pins: stage one read only by stage two
  logic [`SJD_BSR_W-1:0] ringMeta_q;
  logic [`SJD_BSR_W-1:0] ringSync_q;

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      ringMeta_q <= '0;
      ringSync_q <= '0;
    end
    else
    begin
      ringMeta_q <= ringIn;
      ringSync_q <= ringMeta_q;
    end
  end

  // ==========================================================
  // state machine
  sjd_tap_state_t tapState_q;
  sjd_tap_state_t tapState_d;

  always_comb
  begin
    case (tapState_q)
      TLR: tapState_d = tmsSync ? TLR : RTI;
      RTI: tapState_d = tmsSync ? SEL_DR : RTI;
      SEL_DR: tapState_d = tmsSync ? SEL_IR : CAP_DR;
      CAP_DR: tapState_d = tmsSync ? EX1_DR : SH_DR;
      SH_DR: tapState_d = tmsSync ? EX1_DR : SH_DR;
      EX1_DR: tapState_d = tmsSync ? UPD_DR : PAU_DR;
      PAU_DR: tapState_d = tmsSync ? EX2_DR : PAU_DR;
      EX2_DR: tapState_d = tmsSync ? UPD_DR : SH_DR;
      UPD_DR: tapState_d = tmsSync ? SEL_DR : RTI;
      SEL_IR: tapState_d = tmsSync ? TLR : CAP_IR;
      CAP_IR: tapState_d = tmsSync ? EX1_IR : SH_IR;
      SH_IR: tapState_d = tmsSync ? EX1_IR : SH_IR;
      EX1_IR: tapState_d = tmsSync ? UPD_IR : PAU_IR;
      PAU_IR: tapState_d = tmsSync ? EX2_IR : PAU_IR;
      EX2_IR: tapState_d = tmsSync ? UPD_IR : SH_IR;
      UPD_IR: tapState_d = tmsSync ? SEL_DR : RTI;
      default: tapState_d = TLR;
    endcase
  end

  // tms is taken only on the test clock's rising edge
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      tapState_q <= TLR;
    else if (tckRise)
      tapState_q <= tapState_d;
  end

  // ==========================================================
  // state and instruction decode
  logic [`SJD_IR_W-1:0] irShift_q;
  logic [`SJD_IR_W-1:0] irActive_q;

  wire inTlr = (tapState_q == TLR);
  wire capIr = tckRise & (tapState_q == CAP_IR);
  wire shIr = tckRise & (tapState_q == SH_IR);
  wire updIr = tckFall & (tapState_q == UPD_IR);
  wire capDr = tckRise & (tapState_q == CAP_DR);
  wire shDr = tckRise & (tapState_q == SH_DR);
  wire updDr = tckFall & (tapState_q == UPD_DR);
  wire shiftState = (tapState_q == SH_IR) | (tapState_q == SH_DR);
  wire fallShIr = tckFall & (tapState_q == SH_IR);
  wire fallShDr = tckFall & (tapState_q == SH_DR);

  wire opExtest = (irActive_q == `SJD_OP_EXTEST);
  wire opIdcode = (irActive_q == `SJD_OP_IDCODE);
  wire opSampleZ = (irActive_q == `SJD_OP_SAMPLEZ);
  wire opSample = (irActive_q == `SJD_OP_SAMPLE);
  wire selBsr = opExtest | opSampleZ | opSample;
  wire selId = opIdcode;
  // reserved, private and bypass codes all fall through to bypass
  wire selBypass = ~selBsr & ~selId;
  // preload only meaningful for the two codes that may drive pins later
  wire bsrLoadUpd = opExtest | opSample;

  // ==========================================================
  // instruction register
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      irShift_q <= `SJD_IR_CAPTURE;
    else if (capIr)
      irShift_q <= `SJD_IR_CAPTURE;
    else if (shIr)
      irShift_q <= {tdiSync, irShift_q[`SJD_IR_W-1:1]};
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      irActive_q <= `SJD_IR_RESET;
    else if (inTlr)
      irActive_q <= `SJD_IR_RESET;
    else if (updIr)
      irActive_q <= irShift_q;
  end

  // ==========================================================
  // data registers
  logic bypass_q;
  logic [`SJD_ID_W-1:0] idShift_q;
  logic [`SJD_BSR_W-1:0] bsr_q;
  logic [`SJD_BSR_W-1:0] bsrUpd_q;

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      bypass_q <= `SJD_BYPASS_CAPTURE;
    else if (capDr & selBypass)
      bypass_q <= `SJD_BYPASS_CAPTURE;
    else if (shDr & selBypass)
      bypass_q <= tdiSync;
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      idShift_q <= '0;
    else if (capDr & selId)
      idShift_q <= ID_VALUE;
    else if (shDr & selId)
      idShift_q <= {tdiSync, idShift_q[`SJD_ID_W-1:1]};
  end

  // capture of async ring is only repeatable if the ram holds its pins still
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      bsr_q <= '0;
    else if (capDr & selBsr)
      bsr_q <= ringSync_q;
    else if (shDr & selBsr)
      bsr_q <= {tdiSync, bsr_q[`SJD_BSR_W-1:1]};
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      bsrUpd_q <= '0;
    else if (updDr & bsrLoadUpd)
      bsrUpd_q <= bsr_q;
  end

  // ==========================================================
  // serial output, falling test clock only
  wire drBit = selBsr ? bsr_q[0] : (selId ? idShift_q[0] : bypass_q);
  wire serialBit = (tapState_q == SH_IR) ? irShift_q[0] : drBit;

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      tdo <= `SJD_TDO_RESET;
      tdoEnable <= 1'b0;
    end
    else if (tckFall)
    begin
      tdo <= serialBit;
      tdoEnable <= shiftState;
    end
  end

  // ==========================================================
  // ram-side effects
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      ramHighZ <= 1'b0;
      ramDriveScan <= 1'b0;
      ramPinOut <= '0;
      activeInstr <= `SJD_IR_RESET;
    end
    else
    begin
      ramHighZ <= opSampleZ;
      ramDriveScan <= opExtest;
      ramPinOut <= bsrUpd_q;
      activeInstr <= irActive_q;
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  a_tlr_loads_id: assert property (inTlr |=> irActive_q == `SJD_OP_IDCODE)
    else $error("reset state did not load identification code");
  a_capture_ir_pattern: assert property (capIr |=> irShift_q[1:0] == 2'h1)
    else $error("capture-ir pattern wrong");
  a_ir_holds_between: assert property (!updIr && !inTlr |=> $stable(irActive_q))
    else $error("instruction changed outside update-ir");
  a_ir_lsb_first: assert property (fallShIr |=> tdo == $past(irShift_q[0]))
    else $error("instruction not shifted lsb first");
  a_extest_path: assert property (fallShDr && opExtest |=> tdo == $past(bsr_q[0]))
    else $error("external test path not on boundary register");
  a_idcode_capture: assert property (
    capDr && opIdcode |=> idShift_q == ID_VALUE ##0 idShift_q[0] == ID_VALUE[0])
    else $error("identification capture wrong");
  a_samplez_highz: assert property (opSampleZ |=> ramHighZ && !ramDriveScan)
    else $error("high-z not forced");
  a_sample_capture: assert property (capDr && opSample |=> bsr_q == $past(ringSync_q))
    else $error("sample did not capture ring");
  a_bypass_path: assert property (
    fallShDr && selBypass |=> tdo == $past(bypass_q))
    else $error("bypass path wrong");
  a_bypass_no_side: assert property (selBypass |=> !ramHighZ && !ramDriveScan)
    else $error("bypass code caused side effect");
  a_extest_drive: assert property (
    opExtest |=> ramDriveScan ##1 ramPinOut == $past(bsrUpd_q))
    else $error("external test pins not driven from cells");
  a_tdo_fall_only: assert property (!tckFall |=> $stable(tdo))
    else $error("tdo changed off falling edge");

  c_ir_update: cover property (updIr ##1 irActive_q == `SJD_OP_BYPASS);
  c_id_shift: cover property (shDr && opIdcode);
  c_extest_drive: cover property (ramDriveScan && updDr);
  c_samplez: cover property (ramHighZ);

endmodule : sjd_tap_decoder

`default_nettype wire

//--- verification/sjd_scan_ctrl.sv
// scan controller model: drives the serial test pins, reads serial out
// assumes a 100 MHz clk; test clock period is sixteen clk, stands low between steps
`timescale 1ns/1ps
`default_nettype none

module sjd_scan_ctrl (
  input wire logic clk,
  input wire logic tdo,
  output var sjd_pkg::sjd_pins_t pins
);
  import sjd_pkg::*;

  // ==========================================================
  // pins
  initial pins = '0;

  // ==========================================================
  // one test-clock period; tdo taken just before the rise
  task automatic step(input logic tmsV, input logic tdiV, output logic tdoV);
    @(negedge clk);
    pins.tms = tmsV;
    pins.tdi = tdiV;
    repeat (4) @(negedge clk);
    tdoV = tdo;
    pins.tck = 1'b1;
    // tms and tdi held across the rise, far beyond the sync delay
    repeat (8) @(negedge clk);
    pins.tck = 1'b0;
    repeat (3) @(negedge clk);
  endtask : step
endmodule : sjd_scan_ctrl

`default_nettype wire

//--- verification/sjd_tap_decoder_tb_top.sv
// bench for the scan-port instruction decoder
// assumes the design files and the scan controller model are compiled first
`timescale 1ns/1ps
`default_nettype none
`define SJD_CHK(nm, e, g) \
  begin \
    cmp_count++; \
    if ((g) !== (e)) \
    begin \
      n_fail++; \
      $display("unexpected %s exp %h got %h", nm, e, g); \
    end \
  end

module sjd_tap_decoder_tb_top;
  import sjd_pkg::*;
  // arbitrary identification value, bit 0 high
  localparam logic [31:0] ID_VAL = 32'h5B2D_7E49;
  logic clk;
  logic reset;
  logic [7:0] ringIn;
  sjd_pins_t pins;
  logic tdo;
  logic tdoEnable;
  logic ramHighZ;
  logic ramDriveScan;
  logic [7:0] ramPinOut;
  logic [2:0] activeInstr;
  int n_fail;
  int cmp_count;

  sjd_tap_decoder #(.ID_VALUE(ID_VAL)) dut_u (
    .clk(clk), .reset(reset), .pins(pins), .ringIn(ringIn), .tdo(tdo),
    .tdoEnable(tdoEnable), .ramHighZ(ramHighZ), .ramDriveScan(ramDriveScan),
    .ramPinOut(ramPinOut), .activeInstr(activeInstr)
  );
  sjd_scan_ctrl ctrl_u (.clk(clk), .tdo(tdo), .pins(pins));

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // ==========================================================
  // navigation and shifting, tms bits taken lsb first
  task automatic nav(input logic [7:0] seq, input int n);
    logic b;
    for (int i = 0; i < n; i++)
    begin
      ctrl_u.step(seq[i], 1'b0, b);
    end
  endtask : nav

  task automatic shiftBits(input int n, input logic [31:0] inV, output logic [31:0] outV);
    logic b;
    outV = '0;
    for (int i = 0; i < n; i++)
    begin
      ctrl_u.step(i == n - 1, inV[i], b);
      outV[i] = b;
    end
  endtask : shiftBits

  task automatic loadIr(input logic [2:0] code);
    logic [31:0] o;
    logic [2:0] prev;
    prev = activeInstr;
    nav(8'h03, 4);
    shiftBits(3, {29'h0, code}, o);
    `SJD_CHK("captured ir", 3'h1, o[2:0])
    `SJD_CHK("instr before update", prev, activeInstr)
    nav(8'h01, 2);
    repeat (3) @(negedge clk);
    `SJD_CHK("active instr", code, activeInstr)
  endtask : loadIr

  task automatic scanDr(input int n, input logic [31:0] inV, output logic [31:0] outV);
    nav(8'h01, 3);
    repeat (2) @(negedge clk);
    `SJD_CHK("drive flag shift", 1'b1, tdoEnable)
    shiftBits(n, inV, outV);
    nav(8'h01, 2);
    repeat (3) @(negedge clk);
    `SJD_CHK("drive flag idle", 1'b0, tdoEnable)
  endtask : scanDr

  // ==========================================================
  // scenarios
  task automatic chkReset();
    `SJD_CHK("reset instr", 3'h1, activeInstr)
    `SJD_CHK("reset high-z", 1'b0, ramHighZ)
    `SJD_CHK("reset pin drive", 1'b0, ramDriveScan)
    `SJD_CHK("reset tdo", 1'b0, tdo)
    `SJD_CHK("reset tdo drive", 1'b0, tdoEnable)
    `SJD_CHK("reset pin latch", 8'h00, ramPinOut)
  endtask : chkReset

  task automatic idScan();
    logic [31:0] o;
    nav(8'h00, 1);
    scanDr(32, 32'hFFFF_FFFF, o);
    `SJD_CHK("id value", ID_VAL, o)
  endtask : idScan

  task automatic allCodes();
    logic [31:0] o;
    logic [7:0] pat;
    logic [7:0] pinPrev;
    logic [7:0] expDr;
    for (int c = 0; c < 8; c++)
    begin
      pat = 8'hA5 ^ 8'(c * 17);
      ringIn = 8'h3C ^ 8'(c * 9);
      loadIr(3'(c));
      `SJD_CHK("high-z", c == 2, ramHighZ)
      `SJD_CHK("pin drive", c == 0, ramDriveScan)
      pinPrev = ramPinOut;
      scanDr(8, {24'h0, pat}, o);
      // bypass path: one zero, then tdi one step late
      if (c == 1) expDr = ID_VAL[7:0];
      else if (c == 0 || c == 2 || c == 4) expDr = ringIn;
      else expDr = {pat[6:0], 1'b0};
      `SJD_CHK("dr scan", expDr, o[7:0])
      `SJD_CHK("pin latch", (c == 0 || c == 4) ? pat : pinPrev, ramPinOut)
    end
  endtask : allCodes

  task automatic resets();
    loadIr(3'h7);
    nav(8'h1F, 5);
    repeat (3) @(negedge clk);
    `SJD_CHK("instr after tms reset", 3'h1, activeInstr)
    nav(8'h00, 1);
    loadIr(3'h2);
    reset = 1'b1;
    @(negedge clk);
    `SJD_CHK("instr in reset", 3'h1, activeInstr)
    `SJD_CHK("high-z in reset", 1'b0, ramHighZ)
    reset = 1'b0;
    idScan();
  endtask : resets

  // ==========================================================
  // verdict
  task automatic tally_and_finish();
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
    begin
      $display("TEST PASSED");
    end
    else
    begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : tally_and_finish

  initial
  begin
    reset = 1'b1;
    ringIn = 8'h00;
    n_fail = 0;
    cmp_count = 0;
    repeat (5) @(negedge clk);
    reset = 1'b0;
    repeat (2) @(negedge clk);
    chkReset();
    idScan();
    allCodes();
    resets();
    tally_and_finish();
  end

  // hang guard, far above the expected run length
  initial
  begin
    #500000;
    n_fail++;
    $display("unexpected timeout exp %h got %h", 1'b0, 1'b1);
    tally_and_finish();
  end
endmodule : sjd_tap_decoder_tb_top

`default_nettype wire
